// ==== phy_next_page_and_mode_registers_tb.sv ====
// self-checking bench for the register slice, frames via manager model
// assumes strap address 05h; broadcast strap 0, raised for a second reset
`timescale 1ns/1ps
`default_nettype none
module phy_next_page_and_mode_registers_tb;
    import pnpm_pkg::*;
    localparam logic [4:0] ADDR = 5'h05;
    logic core_clk = 1'b0, nrst = 1'b0, start = 1'b0, load = 1'b0;
    logic sym_err = 1'b0, mdio_out, mdio_oe, mdc, drv_en, drv_val, rd_done;
    logic slow, pdn, bcast, b2b, mii, mdio_line;
    logic bstrap = 1'b0;
    logic [1:0] op = 2'h0;
    logic [4:0] phyad = 5'h00, regad = 5'h00;
    logic [15:0] wdata = 16'h0000, ppage = 16'h0000, rdata, r, p;
    logic [10:0] msg;
    logic [15:0] exp_q[$];
    int error_cnt = 0, checked = 0, n;
    // pull-up when nobody drives
    assign mdio_line = mdio_oe ? mdio_out : (drv_en ? drv_val : 1'b1);
    always #2.5 core_clk = ~core_clk;
    pnpm_regs i_pnpm_regs (.core_clk(core_clk), .nrst(nrst), .mdc(mdc),
        .mdio_in(mdio_line), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
        .phy_addr_strap(ADDR), .broadcast_disable_strap(bstrap),
        .partner_page(ppage), .partner_page_load(load),
        .symbol_error_frame(sym_err), .local_next_page_msg(msg),
        .slow_osc_select(slow), .analog_power_down(pdn),
        .broadcast_disable(bcast), .back_to_back_mode(b2b),
        .mii_mode_force(mii));
    pnpm_mdio_master i_pnpm_mdio_master (.core_clk(core_clk),
        .mdio_line(mdio_line), .start(start), .op(op), .phyad(phyad),
        .regad(regad), .wdata(wdata), .mdc(mdc), .drv_en(drv_en),
        .drv_val(drv_val), .rd_done(rd_done), .rdata(rdata));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, seen,
                exp);
        end
    endtask : chk
    task automatic results();
        $display("errors %0d, comparisons %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : results
    // a frame lasts 521 clocks in the model
    task automatic frm(input logic [1:0] o, input logic [4:0] a,
        input logic [4:0] g, input logic [15:0] d);
        op <= o;
        phyad <= a;
        regad <= g;
        wdata <= d;
        start <= 1'b1;
        @(posedge core_clk);
        start <= 1'b0;
        repeat (530) @(posedge core_clk);
    endtask : frm
    task automatic rd(input logic [4:0] a, input logic [4:0] g,
        input logic [15:0] e);
        exp_q.push_back(e);
        frm(PNPM_OP_READ, a, g, 16'h0000);
    endtask : rd
    task automatic wr(input logic [4:0] g, input logic [15:0] d);
        frm(PNPM_OP_WRITE, ADDR, g, d);
    endtask : wr
    // read results are matched against the oldest note
    always @(posedge core_clk) begin
        if (rd_done === 1'b1) chk(rdata, exp_q.pop_front());
    end
    // watchdog sized above the ~78k cycles the tests need
    initial begin
        repeat (100000) @(posedge core_clk);
        error_cnt++;
        results();
    end
    // main sequence
    initial begin
        void'($urandom(32'hCA25));
        repeat (16) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (8) @(posedge core_clk);
        chk({15'h0000, mii}, 16'h0001);
        rd(ADDR, PNPM_LOCAL_NP_ADDR, 16'h0001);
        rd(ADDR, PNPM_PARTNER_NP_ADDR, 16'h0000);
        rd(ADDR, PNPM_AFE_CTRL_ADDR, 16'h0000);
        rd(ADDR, PNPM_SYM_ERR_ADDR, 16'h0000);
        rd(ADDR, PNPM_MODE_OVR_ADDR, 16'h0001);
        rd(ADDR, 5'h03, 16'h0000);
        rd(ADDR + 5'h01, PNPM_LOCAL_NP_ADDR, 16'hFFFF);
        r = 16'($urandom);
        wr(PNPM_LOCAL_NP_ADDR, r);
        chk({5'h00, msg}, {5'h00, r[10:0]});
        rd(ADDR, PNPM_LOCAL_NP_ADDR, {5'h00, r[10:0]});
        // partner word, then a write that must not land
        p = 16'($urandom);
        ppage <= p;
        load <= 1'b1;
        @(posedge core_clk);
        load <= 1'b0;
        wr(PNPM_PARTNER_NP_ADDR, ~p);
        rd(ADDR, PNPM_PARTNER_NP_ADDR, p);
        for (int k = 1; k >= 0; k--) begin
            wr(PNPM_AFE_CTRL_ADDR, 16'(k) << PNPM_SLOW_OSC_BIT);
            chk({15'h0000, slow}, 16'(k));
            chk({15'h0000, pdn}, 16'(k));
        end
        n = $urandom_range(40, 1);
        repeat (n) begin
            sym_err <= 1'b1;
            @(posedge core_clk);
            sym_err <= 1'b0;
            @(posedge core_clk);
        end
        rd(ADDR, PNPM_SYM_ERR_ADDR, 16'(n));
        rd(ADDR, PNPM_SYM_ERR_ADDR, 16'h0000);
        sym_err <= 1'b1;
        repeat (65540) @(posedge core_clk);
        sym_err <= 1'b0;
        rd(ADDR, PNPM_SYM_ERR_ADDR, 16'hFFFF);
        wr(PNPM_MODE_OVR_ADDR, 16'hFFFF); // bits 9, 7 and 0 together
        rd(ADDR, PNPM_MODE_OVR_ADDR, 16'hFBFF);
        chk({13'h0000, bcast, b2b, mii}, 16'h0007);
        rd(5'h00, PNPM_LOCAL_NP_ADDR, 16'hFFFF);
        wr(PNPM_MODE_OVR_ADDR, 16'h0000);
        chk({13'h0000, bcast, b2b, mii}, 16'h0000);
        rd(5'h00, PNPM_LOCAL_NP_ADDR, {5'h00, r[10:0]});
        // second reset with the strap raised: zero loses broadcast
        bstrap <= 1'b1;
        nrst <= 1'b0;
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (8) @(posedge core_clk);
        chk({13'h0000, bcast, b2b, mii}, 16'h0005);
        rd(5'h00, PNPM_LOCAL_NP_ADDR, 16'hFFFF);
        rd(ADDR, PNPM_LOCAL_NP_ADDR, {5'h00, PNPM_LOCAL_MSG_RST});
        results();
    end
endmodule : phy_next_page_and_mode_registers_tb
`default_nettype wire

// ==== pnpm_mdio_master.sv ====
// station manager model: one management frame per start pulse
// assumes the bench resolves the shared data line with a pull-up
`timescale 1ns/1ps
`default_nettype none
module pnpm_mdio_master
    import pnpm_pkg::*;
(
    input wire logic core_clk,
    input wire logic mdio_line,
    input wire logic start,
    input wire logic [1:0] op,
    input wire logic [4:0] phyad,
    input wire logic [4:0] regad,
    input wire logic [15:0] wdata,
    output logic mdc,
    output logic drv_en,
    output logic drv_val,
    output logic rd_done,
    output logic [15:0] rdata
);
    logic [63:0] frame;
    // idle: clock parked low, line released to the pull-up
    initial begin
        mdc = 1'b0;
        drv_en = 1'b0;
        drv_val = 1'b1;
        rd_done = 1'b0;
        rdata = 16'h0000;
    end
    // half periods of 4 clocks keep mdc above the 3-cycle minimum
    always @(posedge core_clk) begin
        rd_done <= 1'b0;
        if (start) begin
            frame = {32'hFFFFFFFF, 2'h1, op, phyad, regad, 2'h2, wdata};
            for (int i = 0; i < 64; i++) begin
                mdc <= 1'b0;
                drv_en <= !(op == PNPM_OP_READ && i >= 46); // read turnaround
                drv_val <= frame[63 - i];
                repeat (4) @(posedge core_clk);
                mdc <= 1'b1;
                // device moved its bit after the previous rise
                if (i >= 48) rdata[63 - i] <= mdio_line;
                repeat (4) @(posedge core_clk);
            end
            mdc <= 1'b0;
            drv_en <= 1'b0;
            repeat (8) @(posedge core_clk);
            rd_done <= (op == PNPM_OP_READ);
        end
    end
endmodule : pnpm_mdio_master
`default_nettype wire

// ==== pnpm_pkg.sv ====
// constants for the next-page / mode register slice of the phy
// management bank; shared by the slice and its testbench
package pnpm_pkg;
    // register addresses on the management frame
    localparam logic [4:0] PNPM_LOCAL_NP_ADDR = 5'h07;
    localparam logic [4:0] PNPM_PARTNER_NP_ADDR = 5'h08;
    localparam logic [4:0] PNPM_AFE_CTRL_ADDR = 5'h11;
    localparam logic [4:0] PNPM_SYM_ERR_ADDR = 5'h15;
    localparam logic [4:0] PNPM_MODE_OVR_ADDR = 5'h16;
    // reset values
    localparam logic [10:0] PNPM_LOCAL_MSG_RST = 11'h001;
    localparam logic [15:0] PNPM_PARTNER_RST = 16'h0000;
    localparam logic [15:0] PNPM_AFE_CTRL_RST = 16'h0000;
    localparam logic [15:0] PNPM_SYM_ERR_RST = 16'h0000;
    localparam logic [15:0] PNPM_MODE_OVR_RST = 16'h0001;
    // field positions
    localparam int PNPM_SLOW_OSC_BIT = 5;
    localparam int PNPM_OVR_RO_BIT = 10;
    localparam int PNPM_OVR_BCAST_BIT = 9;
    localparam int PNPM_OVR_B2B_BIT = 7;
    localparam int PNPM_OVR_MII_BIT = 0;
    localparam logic [15:0] PNPM_OVR_WR_MASK = 16'hFBFF;
    // management frame timing, in mdc bits
    localparam logic [5:0] PNPM_PREAMBLE_BITS = 6'h20;
    localparam logic [5:0] PNPM_HDR_BITS = 6'h0D;
    localparam logic [5:0] PNPM_WR_BITS = 6'h12;
    localparam logic [5:0] PNPM_RD_END = 6'h11;
    localparam logic [1:0] PNPM_OP_READ = 2'h2;
    localparam logic [1:0] PNPM_OP_WRITE = 2'h1;
    typedef enum logic [1:0] {
        PNPM_IDLE, PNPM_HDR, PNPM_WRITE, PNPM_READ
    } pnpm_fsm_type;
endpackage : pnpm_pkg

// ==== pnpm_regs.sv ====
// management-side register slice: local next page message, partner next
// page copy, slow oscillator control, symbol error counter, overrides.
// assumes mdc/mdio come from pins (async) and the autoneg/receive logic
// feeding partner_page and symbol_error_frame runs on core_clk.
`timescale 1ns/1ps
`default_nettype none
module pnpm_regs
    import pnpm_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe,
    input wire logic [4:0] phy_addr_strap,
    input wire logic broadcast_disable_strap,
    input wire logic [15:0] partner_page,
    input wire logic partner_page_load,
    input wire logic symbol_error_frame,
    output logic [10:0] local_next_page_msg,
    output logic slow_osc_select,
    output logic analog_power_down,
    output logic broadcast_disable,
    output logic back_to_back_mode,
    output logic mii_mode_force
);
    typedef struct packed {
        logic [2:0] mdc_s;
        logic [2:0] mdio_s;
        logic mdc_lvl;
        logic mdio_lvl;
        pnpm_fsm_type fsm;
        logic [5:0] cnt;
        logic [15:0] shreg;
        logic out;
        logic oe;
        logic [10:0] msg;
        logic [15:0] partner;
        logic [15:0] afe;
        logic [15:0] sym_cnt;
        logic [15:0] ovr;
        logic strap_done;
        logic [4:0] phy_addr;
        logic bcast_strap;
        logic bcast_dis;
        logic [4:0] reg_addr;
    } pnpm_state_type;

    pnpm_state_type st_q, st_d;
    logic mdc_rise, bit_in, wr_apply, rd_clear;

    // register read decode
    function automatic logic [15:0] reg_read(input pnpm_state_type s,
                                             input logic [4:0] a);
        case (a)
            PNPM_LOCAL_NP_ADDR: reg_read = {5'h00, s.msg};
            PNPM_PARTNER_NP_ADDR: reg_read = s.partner;
            PNPM_AFE_CTRL_ADDR: reg_read = s.afe;
            PNPM_SYM_ERR_ADDR: reg_read = s.sym_cnt;
            PNPM_MODE_OVR_ADDR: reg_read = s.ovr;
            default: reg_read = 16'h0000;
        endcase
    endfunction : reg_read

    // next state: pin sync, frame engine, register updates
    always_comb begin
        st_d = st_q;
        mdc_rise = 1'b0;
        wr_apply = 1'b0;
        rd_clear = 1'b0;
        st_d.mdc_s = {st_q.mdc_s[1:0], mdc};
        st_d.mdio_s = {st_q.mdio_s[1:0], mdio_in};
        // a level counts only once stages two and three agree
        if (st_q.mdc_s[1] == st_q.mdc_s[2]) begin
            st_d.mdc_lvl = st_q.mdc_s[2];
        end
        if (st_q.mdio_s[1] == st_q.mdio_s[2]) begin
            st_d.mdio_lvl = st_q.mdio_s[2];
        end
        mdc_rise = st_d.mdc_lvl && !st_q.mdc_lvl;
        bit_in = st_d.mdio_lvl;
        // straps caught once, on the first edge after reset release
        if (!st_q.strap_done) begin
            st_d.strap_done = 1'b1;
            st_d.phy_addr = phy_addr_strap;
            st_d.bcast_strap = broadcast_disable_strap;
        end
        if (mdc_rise) begin
            case (st_q.fsm)
                PNPM_IDLE: begin
                    // preamble suppression is not supported
                    if (bit_in) begin
                        if (st_q.cnt != PNPM_PREAMBLE_BITS) begin
                            st_d.cnt = st_q.cnt + 6'h01;
                        end
                    end else if (st_q.cnt == PNPM_PREAMBLE_BITS) begin
                        st_d.fsm = PNPM_HDR;
                        st_d.cnt = 6'h00;
                    end else begin
                        st_d.cnt = 6'h00;
                    end
                end
                PNPM_HDR: begin
                    st_d.shreg = {st_q.shreg[14:0], bit_in};
                    st_d.cnt = st_q.cnt + 6'h01;
                    if (st_d.cnt == PNPM_HDR_BITS) begin
                        st_d.cnt = 6'h00;
                        st_d.fsm = PNPM_IDLE;
                        // register address kept for the write at frame end
                        st_d.reg_addr = st_d.shreg[4:0];
                        // address zero is broadcast unless disabled
                        if (st_d.shreg[12]
                            && (st_d.shreg[9:5] == st_q.phy_addr
                            || (st_d.shreg[9:5] == 5'h00
                            && !st_q.bcast_dis))) begin
                            if (st_d.shreg[11:10] == PNPM_OP_READ) begin
                                st_d.fsm = PNPM_READ;
                                st_d.shreg = reg_read(st_q, st_d.reg_addr);
                                // only the counter clears on being read
                                rd_clear = st_d.reg_addr
                                    == PNPM_SYM_ERR_ADDR;
                            end else if (st_d.shreg[11:10]
                                == PNPM_OP_WRITE) begin
                                st_d.fsm = PNPM_WRITE;
                            end
                        end
                    end
                end
                PNPM_WRITE: begin
                    // register address stays in shreg[4:0] until ta ends
                    st_d.cnt = st_q.cnt + 6'h01;
                    if (st_q.cnt < 6'h02) begin
                        st_d.shreg = st_q.shreg;
                    end else begin
                        st_d.shreg = {st_q.shreg[14:0], bit_in};
                    end
                    if (st_d.cnt == PNPM_WR_BITS) begin
                        wr_apply = 1'b1;
                        st_d.fsm = PNPM_IDLE;
                        st_d.cnt = 6'h00;
                    end
                end
                PNPM_READ: begin
                    // first edge ends ta's z bit, then drive 0, then data
                    st_d.cnt = st_q.cnt + 6'h01;
                    st_d.oe = 1'b1;
                    if (st_q.cnt == 6'h00) begin
                        st_d.out = 1'b0;
                    end else begin
                        st_d.out = st_q.shreg[15];
                        st_d.shreg = {st_q.shreg[14:0], 1'b0};
                    end
                    if (st_q.cnt == PNPM_RD_END) begin
                        st_d.oe = 1'b0;
                        st_d.out = 1'b0;
                        st_d.fsm = PNPM_IDLE;
                        st_d.cnt = 6'h00;
                    end
                end
                default: begin
                    st_d.fsm = PNPM_IDLE;
                    st_d.cnt = 6'h00;
                end
            endcase
        end
        // write target was latched at header time in reg_addr
        if (wr_apply) begin
            case (st_q.reg_addr)
                PNPM_LOCAL_NP_ADDR: st_d.msg = st_d.shreg[10:0];
                PNPM_AFE_CTRL_ADDR: st_d.afe = st_d.shreg;
                PNPM_MODE_OVR_ADDR:
                    st_d.ovr = st_d.shreg & PNPM_OVR_WR_MASK;
                default: ;
            endcase
        end
        if (partner_page_load) begin
            st_d.partner = partner_page;
        end
        // an error arriving with the clearing read is kept as one count
        if (rd_clear) begin
            st_d.sym_cnt = {15'h0000, symbol_error_frame};
        end else if (symbol_error_frame && st_q.sym_cnt != 16'hFFFF) begin
            st_d.sym_cnt = st_q.sym_cnt + 16'h0001;
        end
        st_d.bcast_dis = st_d.ovr[PNPM_OVR_BCAST_BIT]
            || st_d.bcast_strap;
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= '0;
            st_q.fsm <= PNPM_IDLE;
            st_q.msg <= PNPM_LOCAL_MSG_RST;
            st_q.partner <= PNPM_PARTNER_RST;
            st_q.afe <= PNPM_AFE_CTRL_RST;
            st_q.sym_cnt <= PNPM_SYM_ERR_RST;
            st_q.ovr <= PNPM_MODE_OVR_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs straight from state flops
    assign mdio_out = st_q.out;
    assign mdio_oe = st_q.oe;
    assign local_next_page_msg = st_q.msg;
    assign slow_osc_select = st_q.afe[PNPM_SLOW_OSC_BIT];
    assign analog_power_down = st_q.afe[PNPM_SLOW_OSC_BIT];
    assign broadcast_disable = st_q.bcast_dis;
    // pairing with the mii bit is the controller's job
    assign back_to_back_mode = st_q.ovr[PNPM_OVR_B2B_BIT];
    assign mii_mode_force = st_q.ovr[PNPM_OVR_MII_BIT];

    msg_hold_a: assert property (
        @(posedge core_clk) disable iff (!nrst)
        !(wr_apply && st_q.reg_addr == PNPM_LOCAL_NP_ADDR)
        |=> $stable(st_q.msg))
        else $error("local message changed without a write");
    partner_load_a: assert property (
        @(posedge core_clk) disable iff (!nrst)
        partner_page_load |=> st_q.partner == $past(partner_page))
        else $error("partner page not captured");
    partner_hold_a: assert property (
        @(posedge core_clk) disable iff (!nrst)
        !partner_page_load |=> $stable(st_q.partner))
        else $error("partner page changed without load");
    slow_osc_pd_a: assert property (
        @(posedge core_clk) disable iff (!nrst)
        wr_apply && st_q.reg_addr == PNPM_AFE_CTRL_ADDR
        && st_d.shreg[PNPM_SLOW_OSC_BIT]
        |=> slow_osc_select && analog_power_down)
        else $error("slow oscillator did not force power-down");
    counter_inc_a: assert property (
        @(posedge core_clk) disable iff (!nrst)
        symbol_error_frame && !rd_clear && st_q.sym_cnt != 16'hFFFF
        |=> st_q.sym_cnt == $past(st_q.sym_cnt) + 16'h0001)
        else $error("symbol error not counted");
    counter_sat_a: assert property (
        @(posedge core_clk) disable iff (!nrst)
        st_q.sym_cnt == 16'hFFFF && !rd_clear |=> st_q.sym_cnt == 16'hFFFF)
        else $error("symbol error counter wrapped");
    read_clear_a: assert property (
        @(posedge core_clk) disable iff (!nrst)
        rd_clear && !symbol_error_frame |=> st_q.sym_cnt == 16'h0000)
        else $error("counter not cleared by read");
    bcast_ovr_a: assert property (
        @(posedge core_clk) disable iff (!nrst)
        st_q.ovr[PNPM_OVR_BCAST_BIT] |-> broadcast_disable)
        else $error("broadcast override not applied");
    ro_bit_zero_a: assert property (
        @(posedge core_clk) disable iff (!nrst)
        wr_apply |=> !st_q.ovr[PNPM_OVR_RO_BIT])
        else $error("read-only override bit became set");
    mii_write_a: assert property (
        @(posedge core_clk) disable iff (!nrst)
        wr_apply && st_q.reg_addr == PNPM_MODE_OVR_ADDR
        |=> mii_mode_force == $past(st_d.shreg[PNPM_OVR_MII_BIT]))
        else $error("mii override write lost");
endmodule : pnpm_regs
`default_nettype wire
